// *** shared/host_link_control_map.vh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit register words on an AXI4-Lite slave, byte addresses
// Notes:   definitions only
`ifndef HOST_LINK_CONTROL_MAP_VH
`define HOST_LINK_CONTROL_MAP_VH

// =====================================================
// offsets
`define OFS_FLAGS_SET      12'h050
`define OFS_FLAGS_CLEAR    12'h054
`define OFS_SCLK_LO_FIRST  12'h0DC
`define OFS_SCLK_LO_LAST   12'h0F0
`define OFS_SCLK_HI_FIRST  12'h100
`define OFS_SCLK_HI_LAST   12'h11C

// =====================================================
// field positions
`define BIT_PHY_DELEGATED  23
`define BIT_ENHANCE_EN     22
`define BIT_LINK_POWER     19
`define BIT_POSTED_WRITE   18
`define BIT_CONNECT_EN     17
`define BIT_SOFT_RESET     16

// =====================================================
// reset values and timing
`define FLAGS_RESET        32'h0080_0000
`define CLK_PERIOD_NS      100
`define SOFT_RESET_NS      800
// 800 ns at a 100 ns clock, sized for the 4-bit sequencer count
`define SOFT_RESET_CYCLES  4'h8

`endif

// *** rtl/host_link_control_flags.v ***
// Purpose: host control flag register (bits 28..0) behind set/clear ports
// Assumes: AXI4-Lite slave on aclk; inputs synchronous to aclk
// Notes:   link-side window DCh-F0h, 100h-11Ch answered here as stand-in
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`include "host_link_control_map.vh"

module host_link_control_flags (
   // clock, resets and freeze
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        global_reset_n,
   input  wire        clk_en,
   // strap and configuration-space inputs
   input  wire        eeprom_loaded,
   input  wire        eeprom_phy_delegated,
   input  wire        abort_suppress,
   input  wire        sclk_running,
   // write address channel
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // write data channel
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // write response channel
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // read address channel
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // read data channel
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // flag register bits
   output reg         phy_config_delegated,
   output reg         enhancement_enable,
   output reg         link_power_on,
   output reg         posted_write_allow,
   output reg         bus_connect_enable,
   output reg         software_reset_trigger,
   // effects on the rest of the link
   output wire        link_phy_allow,
   output wire        packet_path_enable,
   output wire        link_state_reset
);

   localparam [1:0] RESP_OKAY   = 2'h0;
   localparam [1:0] RESP_SLVERR = 2'h2;
   localparam [3:0]  SR_CYCLES   = `SOFT_RESET_CYCLES;
   localparam [11:0] ADDR_SET    = `OFS_FLAGS_SET;
   localparam [11:0] ADDR_CLEAR  = `OFS_FLAGS_CLEAR;

   // =====================================================
   // write channel capture: address and data in either order
   reg  [11:0] aw_addr;
   reg         aw_held;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         w_held;
   reg  [3:0]  sr_count;
   wire        wr_go;
   wire        hard_reset;
   wire        soft_active;
   wire [31:0] wmask;

   assign hard_reset    = !aresetn || !global_reset_n;
   // a held item closes its own write channel and a waiting response closes both,
   // so the next write cannot overtake the answer to this one
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_go         = aw_held && w_held && !s_axi_bvalid;
   assign wmask         = w_data & {{8{w_strb[3]}}, {8{w_strb[2]}},
                                    {8{w_strb[1]}}, {8{w_strb[0]}}};
   assign soft_active   = software_reset_trigger;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr <= 12'h000;
         aw_held <= 1'b0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         w_held <= 1'b0;
      end else if (clk_en) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // =====================================================
   // link clock domain window decode
   function in_sclk_window;
      input [11:0] a;
      begin
         in_sclk_window = (a >= `OFS_SCLK_LO_FIRST && a <= `OFS_SCLK_LO_LAST) ||
                          (a >= `OFS_SCLK_HI_FIRST && a <= `OFS_SCLK_HI_LAST);
      end
   endfunction

   // =====================================================
   // flag register
   wire at_set   = (aw_addr[11:2] == ADDR_SET[11:2]);
   wire at_clear = (aw_addr[11:2] == ADDR_CLEAR[11:2]);
   wire wr_set   = wr_go && at_set;
   wire wr_clear = wr_go && at_clear;

   // delegation flag survives software reset; strap taken on the clock
   always @(posedge aclk) begin
      if (hard_reset) begin
         phy_config_delegated <= 1'b1;
      end else if (clk_en) begin
         if (eeprom_loaded) begin
            phy_config_delegated <= eeprom_phy_delegated;
         end else if (wr_clear && wmask[`BIT_PHY_DELEGATED] && !soft_active) begin
            phy_config_delegated <= 1'b0;
         end
      end
   end

   // enhancement enable: delegation rules are kept by software, not checked here
   always @(posedge aclk) begin
      if (!aresetn) begin
         enhancement_enable <= 1'b0;
      end else if (clk_en) begin
         if (soft_active) begin
            enhancement_enable <= 1'b0;
         end else if (wr_set && wmask[`BIT_ENHANCE_EN]) begin
            enhancement_enable <= 1'b1;
         end else if (wr_clear && wmask[`BIT_ENHANCE_EN]) begin
            enhancement_enable <= 1'b0;
         end
      end
   end

   // link power: cleared while soft reset runs, like every link flag
   always @(posedge aclk) begin
      if (!aresetn) begin
         link_power_on <= 1'b0;
      end else if (clk_en) begin
         if (soft_active) begin
            link_power_on <= 1'b0;
         end else if (wr_set && wmask[`BIT_LINK_POWER]) begin
            link_power_on <= 1'b1;
         end else if (wr_clear && wmask[`BIT_LINK_POWER]) begin
            link_power_on <= 1'b0;
         end
      end
   end

   // posted writes: changing it while connected is a software error, not caught
   always @(posedge aclk) begin
      if (!aresetn) begin
         posted_write_allow <= 1'b0;
      end else if (clk_en) begin
         if (soft_active) begin
            posted_write_allow <= 1'b0;
         end else if (wr_set && wmask[`BIT_POSTED_WRITE]) begin
            posted_write_allow <= 1'b1;
         end else if (wr_clear && wmask[`BIT_POSTED_WRITE]) begin
            posted_write_allow <= 1'b0;
         end
      end
   end

   // connect flag: aresetn and software reset drop it; global_reset_n does not
   always @(posedge aclk) begin
      if (!aresetn) begin
         bus_connect_enable <= 1'b0;
      end else if (clk_en) begin
         if (soft_active) begin
            bus_connect_enable <= 1'b0;
         end else if (wr_set && wmask[`BIT_CONNECT_EN]) begin
            bus_connect_enable <= 1'b1;
         end else if (wr_clear && wmask[`BIT_CONNECT_EN]) begin
            bus_connect_enable <= 1'b0;
         end
      end
   end

   // =====================================================
   // soft reset sequencer: fixed length, the clear port cannot cut it short
   always @(posedge aclk) begin
      if (!aresetn) begin
         software_reset_trigger <= 1'b0;
         sr_count               <= 4'h0;
      end else if (clk_en) begin
         if (soft_active) begin
            if (sr_count == SR_CYCLES - 4'h1) begin
               software_reset_trigger <= 1'b0;
               sr_count               <= 4'h0;
            end else begin
               sr_count <= sr_count + 4'h1;
            end
         end else if (wr_set && wmask[`BIT_SOFT_RESET]) begin
            software_reset_trigger <= 1'b1;
         end
      end
   end

   // =====================================================
   // effects on the rest of the link
   assign link_phy_allow     = link_power_on;
   assign packet_path_enable = bus_connect_enable && !soft_active;
   assign link_state_reset   = soft_active;

   wire [31:0] flags_view;

   assign flags_view = {3'b000,                 // upper bits kept outside this block
                        5'b0_0000,
                        phy_config_delegated,
                        enhancement_enable,
                        2'b00,
                        link_power_on,
                        posted_write_allow,
                        bus_connect_enable,
                        software_reset_trigger,
                        16'h0000};

   // =====================================================
   // write response; decode is combinational, the answer is registered
   reg  [1:0]  next_bresp;
   wire        wr_window;

   assign wr_window = in_sclk_window(aw_addr);

   always @* begin
      next_bresp = RESP_OKAY;
      if (at_set || at_clear) begin
         next_bresp = RESP_OKAY;
      end else if (wr_window && !sclk_running && !abort_suppress) begin
         // stopped link clock: abort unless software asked for quiet completion
         next_bresp = RESP_SLVERR;
      end else if (wr_window) begin
         next_bresp = RESP_OKAY;
      end else begin
         next_bresp = RESP_SLVERR;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= next_bresp;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =====================================================
   // read channel: decode combinational, answer registered one edge later
   reg  [31:0] next_rdata;
   reg  [1:0]  next_rresp;
   wire        rd_flags;
   wire        rd_window;

   assign s_axi_arready = !s_axi_rvalid;
   assign rd_flags      = (s_axi_araddr[11:2] == ADDR_SET[11:2]) ||
                          (s_axi_araddr[11:2] == ADDR_CLEAR[11:2]);
   assign rd_window     = in_sclk_window(s_axi_araddr);

   // unmapped addresses answer an error so a stray pointer shows up at once
   always @* begin
      next_rdata = 32'h0000_0000;
      next_rresp = RESP_OKAY;
      if (rd_flags) begin
         next_rdata = flags_view;
      end else if (rd_window && !sclk_running && !abort_suppress) begin
         next_rresp = RESP_SLVERR;
      end else if (rd_window && !sclk_running) begin
         next_rdata = 32'hFFFF_FFFF;
      end else if (rd_window) begin
         // link-side registers live elsewhere; a running clock reads zero here
         next_rdata = 32'h0000_0000;
      end else begin
         next_rresp = RESP_SLVERR;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// *** tb/host_link_control_flags_asserts.sv ***
// Purpose: temporal checks on the host control flag outputs
// Assumes: clk_en held high by the bench
// Notes:   bound to every instance of the flag register
// ==========================================
// checker
module host_link_control_flags_chk (
   input logic aclk,
   input logic aresetn,
   input logic global_reset_n,
   input logic eeprom_loaded,
   input logic eeprom_phy_delegated,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic phy_config_delegated,
   input logic enhancement_enable,
   input logic link_power_on,
   input logic posted_write_allow,
   input logic bus_connect_enable,
   input logic software_reset_trigger,
   input logic link_phy_allow,
   input logic packet_path_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_PHY_ALLOW: assert property (link_phy_allow == link_power_on)
      else $error("link path gate differs from power flag");
   AST_PATH_OFF: assert property (!bus_connect_enable || software_reset_trigger |-> !packet_path_enable)
      else $error("packet path open while disconnected");
   AST_SRST_LEN: assert property ($rose(software_reset_trigger) |-> software_reset_trigger[*7] ##[1:4] !software_reset_trigger)
      else $error("soft reset flag length wrong");
   AST_SRST_CLR: assert property ($fell(software_reset_trigger) |-> !(enhancement_enable || link_power_on || posted_write_allow || bus_connect_enable))
      else $error("link flags survive soft reset");
   AST_SRST_KEEP: assert property (software_reset_trigger && !eeprom_loaded && global_reset_n |=> $stable(phy_config_delegated))
      else $error("delegation flag moved by soft reset");
   AST_GRST: assert property (!global_reset_n && !eeprom_loaded |=> phy_config_delegated)
      else $error("global reset did not restore delegation");
   AST_EEPROM: assert property (eeprom_loaded && global_reset_n |=> phy_config_delegated == $past(eeprom_phy_delegated))
      else $error("delegation flag not loaded from eeprom");
   AST_RVALID: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
endmodule

bind host_link_control_flags host_link_control_flags_chk u_chk (.*);

// *** tb/test_host_link_control_flags.sv ***
// Purpose: directed register tests of the host control flags
// Assumes: answers come within 64 cycles; clk_en and wstrb held constant
// Notes:   stopped-clock window checked in all four clock/suppress states
module test_host_link_control_flags;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn, global_reset_n, clk_en, eeprom_loaded, eeprom_phy_delegated;
   logic abort_suppress, sclk_running, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, phy_config_delegated, enhancement_enable;
   logic link_power_on, posted_write_allow, bus_connect_enable, software_reset_trigger;
   logic link_phy_allow, packet_path_enable, link_state_reset;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [11:0] addrs[4] = '{12'h0DC, 12'h0F0, 12'h100, 12'h11C};
   int          fails = 0, cmp_count = 0, i, j;
   host_link_control_flags dut_u (.*);
   always #50 aclk = ~aclk;
   // ==========================================
   // bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // handshake loop shared by both directions; releases each item when taken
   task automatic wait_resp(input logic wr);
      int n;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (wr ? s_axi_bvalid : s_axi_rvalid) break;
      end
      if (n == 64) begin
         fails++;
         stop_test();
      end
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      wait_resp(1'h1);
      s_axi_bready <= 1'h0;
      check(s_axi_bresp, er);
   endtask
   task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      wait_resp(1'h0);
      s_axi_rready <= 1'h0;
      check(s_axi_rdata, ed);
      check(s_axi_rresp, er);
   endtask
   // ==========================================
   // sequence
   initial begin
      {aresetn, eeprom_loaded, eeprom_phy_delegated, abort_suppress, sclk_running} = 5'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {global_reset_n, clk_en, s_axi_wstrb} = 6'h3F;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(12'h050, 32'h0080_0000, 2'h0);
      axi_rd(12'h054, 32'h0080_0000, 2'h0);
      axi_wr(12'h050, 32'h1F3C_FFFF, 2'h0);
      axi_rd(12'h054, 32'h008C_0000, 2'h0);
      check(posted_write_allow, 32'h1);
      axi_wr(12'h050, 32'h0002_0000, 2'h0);
      axi_wr(12'h050, 32'h0040_0000, 2'h0);
      axi_rd(12'h050, 32'h00CE_0000, 2'h0);
      check(enhancement_enable, 32'h1);
      check(bus_connect_enable, 32'h1);
      check(packet_path_enable, 32'h1);
      check(link_phy_allow, 32'h1);
      axi_wr(12'h054, 32'h0002_0000, 2'h0);
      check(packet_path_enable, 32'h0);
      axi_wr(12'h050, 32'h0002_0000, 2'h0);
      axi_wr(12'h050, 32'h0001_0000, 2'h0);
      check(link_state_reset, 32'h1);
      check(software_reset_trigger, 32'h1);
      check(packet_path_enable, 32'h0);
      axi_wr(12'h054, 32'h0080_0000, 2'h0);
      axi_rd(12'h050, 32'h0081_0000, 2'h0);
      repeat (12) @(posedge aclk);
      axi_rd(12'h050, 32'h0080_0000, 2'h0);
      check(bus_connect_enable, 32'h0);
      check(phy_config_delegated, 32'h1);
      check(link_phy_allow, 32'h0);
      axi_wr(12'h054, 32'h0080_0000, 2'h0);
      axi_rd(12'h054, 32'h0000_0000, 2'h0);
      global_reset_n <= 1'h0;
      @(posedge aclk);
      global_reset_n <= 1'h1;
      axi_rd(12'h050, 32'h0080_0000, 2'h0);
      eeprom_loaded <= 1'h1;
      @(posedge aclk);
      eeprom_loaded <= 1'h0;
      axi_rd(12'h050, 32'h0000_0000, 2'h0);
      for (i = 0; i < 4; i++) begin
         sclk_running <= i[0];
         abort_suppress <= i[1];
         for (j = 0; j < 4; j++)
            axi_rd(addrs[j], i == 2 ? 32'hFFFF_FFFF : 32'h0, i == 0 ? 2'h2 : 2'h0);
      end
      sclk_running <= 1'h0;
      axi_rd(12'h0D8, 32'h0, 2'h2);
      axi_rd(12'h120, 32'h0, 2'h2);
      abort_suppress <= 1'h0;
      axi_wr(12'h0F0, 32'h0, 2'h2);
      stop_test();
   end
endmodule
